/* logic/trip_regs.svh */
`ifndef TRIP_REGS_SVH
`define TRIP_REGS_SVH
// How it works
// - each external trip reaches the units direct, double-synchronized, or synchronized plus filtered.
// - the filtered path counts six bus clock cycles before passing a level.
// - after reset all three external trips use the direct asynchronous path.
// - route select is three bits: 001 direct, 010 synchronized, 100 filtered.
// - routes a and b at bits 18:16, 26:24; route c at 2:0 next register.
// - per unit select 001 inverts OR of errors, 010 encoder one, 100 encoder two.
// - units one to four at 2:0..26:24; five to seven at 2:0..18:16 next.
// - clock-fault trip asserts whenever oscillator failure or loop slip is detected.
// - clock-fault trip follows sticky status levels, staying asserted until software clears them.
// - enabled debug trip asserts while the processor is halted by the emulator.

`define TRIP_ROUTE_LO_OFFSET   6'h00
`define TRIP_ROUTE_HI_OFFSET   6'h01
`define ENC_SEL_LO_OFFSET      6'h02
`define ENC_SEL_HI_OFFSET      6'h03
`define DEBUG_ENABLE_OFFSET    6'h04
`define TRIP_STATUS_OFFSET     6'h05

`define ROUTE_A_LSB            16
`define ROUTE_B_LSB            24
`define ROUTE_C_LSB            0
`define ENC_FIELD_STRIDE       8
`define ENC_UNITS_LO           4
`define STATUS_EXT_LSB         0
`define STATUS_ENC_LSB         4
`define STATUS_CLK_LSB         12
`define STATUS_DBG_LSB         16
`define STATUS_SYNC_LSB        24

`define SEL_ASYNC              3'h1
`define SEL_SYNC               3'h2
`define SEL_FILTERED           3'h4
`define ENC_SEL_EITHER         3'h1
`define ENC_SEL_ONE            3'h2
`define ENC_SEL_TWO            3'h4

`define ROUTE_RESET            3'h1
`define ENC_SEL_RESET          3'h1
`define DEBUG_ENABLE_RESET     7'h00
`define TRIP_FILTER_CYCLES     6
`endif

/* logic/trip_pkg.sv */
package trip_pkg;

   // all trips are active low, high means no trip
   typedef struct packed {
      logic [6:0] dbg_n;
      logic       clk_n;
      logic [6:0] enc_n;
      logic [2:0] ext_n;
   } trip_bus_type;

   typedef struct packed {
      logic [6:0]      dbg_en;
      logic [6:0][2:0] enc_sel;
      logic [2:0][2:0] route;
   } trip_cfg_type;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_type;

   typedef struct packed {
      trip_cfg_type cfg;
      wb_rsp_type   rsp;
      logic         clk_n;
      logic [6:0]   dbg_n;
   } routing_state_type;

   typedef struct packed {
      logic trip_n;
   } enc_mux_state_type;

endpackage : trip_pkg

/* logic/trip_sync_filter.sv */
`include "trip_regs.svh"

module trip_sync_filter #(
   parameter int FILTER_CYCLES = `TRIP_FILTER_CYCLES
) (
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic pin_n_i,
   output logic      sync_n_o,
   output logic      filt_n_o
);
   localparam int CW = $clog2(FILTER_CYCLES + 1);

   typedef struct packed {
      logic          meta_n;
      logic          sync_n;
      logic          filt_n;
      logic [CW-1:0] cnt;
   } filter_state_type;

   filter_state_type st;
   filter_state_type next_st;

   always_comb begin
      next_st        = st;
      next_st.meta_n = pin_n_i;
      next_st.sync_n = st.meta_n;
      if (st.sync_n == st.filt_n) begin
         next_st.cnt = '0;
      end else if (st.cnt == CW'(FILTER_CYCLES - 1)) begin
         next_st.filt_n = st.sync_n;
         next_st.cnt    = '0;
      end else begin
         next_st.cnt = st.cnt + CW'(1);
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= '{meta_n: 1'b1, sync_n: 1'b1, filt_n: 1'b1, cnt: '0};
      end else begin
         st <= next_st;
      end
   end

   assign sync_n_o = st.sync_n;
   assign filt_n_o = st.filt_n;

endmodule : trip_sync_filter

/* logic/encoder_trip_mux.sv */
`include "trip_regs.svh"

module encoder_trip_mux (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic [2:0] sel_i,
   input  wire logic [1:0] encoder_phase_error_i,
   output logic            trip_n_o
);
   import trip_pkg::*;

   enc_mux_state_type st;
   enc_mux_state_type next_st;

   always_comb begin
      next_st = st;
      unique case (sel_i)
         `ENC_SEL_EITHER: next_st.trip_n = ~(encoder_phase_error_i[0] | encoder_phase_error_i[1]);
         `ENC_SEL_ONE:    next_st.trip_n = ~encoder_phase_error_i[0];
         `ENC_SEL_TWO:    next_st.trip_n = ~encoder_phase_error_i[1];
         default:         next_st.trip_n = 1'b1;
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st <= '{trip_n: 1'b1};
      end else begin
         st <= next_st;
      end
   end

   assign trip_n_o = st.trip_n;

endmodule : encoder_trip_mux

/* logic/pwm_trip_input_routing.sv */
// Added by the designer: the address map and the Wishbone interface to the registers.
`include "trip_regs.svh"

module pwm_trip_input_routing #(
   parameter int FILTER_CYCLES = `TRIP_FILTER_CYCLES
) (
   input  wire logic                  clk_i,
   input  wire logic                  resetn_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   input  wire logic [2:0]            ext_trip_n_i,
   input  wire logic [1:0]            encoder_phase_error_i,
   input  wire logic                  osc_fail_i,
   input  wire logic                  pll_slip_i,
   input  wire logic                  cpu_debug_halt_i,
   output trip_pkg::trip_bus_type     trips_o
);
   import trip_pkg::*;

   localparam int UNITS = 7;
   localparam int EXTS  = 3;

   routing_state_type st;
   routing_state_type next_st;

   logic [EXTS-1:0]  sync_n;
   logic [EXTS-1:0]  filt_n;
   logic [UNITS-1:0] enc_trip_n;
   logic [EXTS-1:0]  ext_out_n;
   logic             bus_req;
   logic [5:0]       word_index;

   // conditioning of the external trip pins
   for (genvar e = 0; e < EXTS; e++) begin : g_ext
      trip_sync_filter #(
         .FILTER_CYCLES (FILTER_CYCLES)
      ) u_filter (
         .clk_i    (clk_i),
         .resetn_i (resetn_i),
         .pin_n_i  (ext_trip_n_i[e]),
         .sync_n_o (sync_n[e]),
         .filt_n_o (filt_n[e])
      );
   end

   // encoder fault trip per unit
   for (genvar u = 0; u < UNITS; u++) begin : g_enc
      encoder_trip_mux u_mux (
         .clk_i                 (clk_i),
         .resetn_i              (resetn_i),
         .sel_i                 (st.cfg.enc_sel[u]),
         .encoder_phase_error_i (encoder_phase_error_i),
         .trip_n_o              (enc_trip_n[u])
      );
   end

   // helpers
   function automatic logic ext_route(input logic [2:0] sel,
                                      input logic       pin_n,
                                      input logic       sync_n_v,
                                      input logic       filt_n_v);
      logic r;
      r = 1'b1;
      unique case (sel)
         `SEL_ASYNC:    r = pin_n;
         `SEL_SYNC:     r = sync_n_v;
         `SEL_FILTERED: r = filt_n_v;
         default:       r = 1'b1;
      endcase
      return r;
   endfunction : ext_route

   // one select field always lives inside one byte lane
   function automatic logic [2:0] field_write(input logic [2:0]  old,
                                              input logic [3:0]  sel,
                                              input logic [31:0] dat,
                                              input int          lsb);
      logic [2:0] r;
      r = old;
      if (sel[lsb / 8]) begin
         r = dat[lsb +: 3];
      end
      return r;
   endfunction : field_write

   function automatic logic [31:0] field_place(input logic [2:0] v,
                                               input int         lsb);
      logic [31:0] r;
      r = 32'(v) << lsb;
      return r;
   endfunction : field_place

   function automatic int enc_lsb(input int unit);
      return `ENC_FIELD_STRIDE * (unit % `ENC_UNITS_LO);
   endfunction : enc_lsb

   // selected external path; the direct path is combinational on purpose
   // so a trip still reaches the units with no bus clock edge at all
   always_comb begin
      for (int e = 0; e < EXTS; e++) begin
         ext_out_n[e] = ext_route(st.cfg.route[e], ext_trip_n_i[e], sync_n[e], filt_n[e]);
      end
   end

   assign bus_req    = wb_cyc_i & wb_stb_i;
   assign word_index = wb_adr_i[7:2];

   // register file and trip state
   always_comb begin
      next_st         = st;
      next_st.rsp.ack = bus_req & ~st.rsp.ack;
      next_st.rsp.dat = 32'h0000_0000;

      if (bus_req && !st.rsp.ack && wb_we_i) begin
         unique case (word_index)
            `TRIP_ROUTE_LO_OFFSET: begin
               next_st.cfg.route[0] = field_write(st.cfg.route[0], wb_sel_i, wb_dat_i, `ROUTE_A_LSB);
               next_st.cfg.route[1] = field_write(st.cfg.route[1], wb_sel_i, wb_dat_i, `ROUTE_B_LSB);
            end
            `TRIP_ROUTE_HI_OFFSET: begin
               next_st.cfg.route[2] = field_write(st.cfg.route[2], wb_sel_i, wb_dat_i, `ROUTE_C_LSB);
            end
            `ENC_SEL_LO_OFFSET: begin
               for (int u = 0; u < `ENC_UNITS_LO; u++) begin
                  next_st.cfg.enc_sel[u] = field_write(st.cfg.enc_sel[u], wb_sel_i, wb_dat_i, enc_lsb(u));
               end
            end
            `ENC_SEL_HI_OFFSET: begin
               for (int u = `ENC_UNITS_LO; u < UNITS; u++) begin
                  next_st.cfg.enc_sel[u] = field_write(st.cfg.enc_sel[u], wb_sel_i, wb_dat_i, enc_lsb(u));
               end
            end
            `DEBUG_ENABLE_OFFSET: begin
               if (wb_sel_i[0]) begin
                  next_st.cfg.dbg_en = wb_dat_i[6:0];
               end
            end
            default: begin
               // status and unmapped words ignore writes but still acknowledge
            end
         endcase
      end

      if (bus_req && !st.rsp.ack && !wb_we_i) begin
         unique case (word_index)
            `TRIP_ROUTE_LO_OFFSET: begin
               next_st.rsp.dat = field_place(st.cfg.route[0], `ROUTE_A_LSB)
                               | field_place(st.cfg.route[1], `ROUTE_B_LSB);
            end
            `TRIP_ROUTE_HI_OFFSET: begin
               next_st.rsp.dat = field_place(st.cfg.route[2], `ROUTE_C_LSB);
            end
            `ENC_SEL_LO_OFFSET: begin
               for (int u = 0; u < `ENC_UNITS_LO; u++) begin
                  next_st.rsp.dat = next_st.rsp.dat | field_place(st.cfg.enc_sel[u], enc_lsb(u));
               end
            end
            `ENC_SEL_HI_OFFSET: begin
               for (int u = `ENC_UNITS_LO; u < UNITS; u++) begin
                  next_st.rsp.dat = next_st.rsp.dat | field_place(st.cfg.enc_sel[u], enc_lsb(u));
               end
            end
            `DEBUG_ENABLE_OFFSET: begin
               next_st.rsp.dat = {25'h0000000, st.cfg.dbg_en};
            end
            `TRIP_STATUS_OFFSET: begin
               next_st.rsp.dat = (32'(ext_out_n)  << `STATUS_EXT_LSB)
                               | (32'(enc_trip_n) << `STATUS_ENC_LSB)
                               | (32'(st.clk_n)   << `STATUS_CLK_LSB)
                               | (32'(st.dbg_n)   << `STATUS_DBG_LSB)
                               | (32'(sync_n)     << `STATUS_SYNC_LSB);
            end
            default: begin
               next_st.rsp.dat = 32'h0000_0000;
            end
         endcase
      end

      // the failure flags are sticky upstream, so no latch is kept here
      next_st.clk_n = ~(osc_fail_i | pll_slip_i);

      for (int u = 0; u < UNITS; u++) begin
         next_st.dbg_n[u] = ~(st.cfg.dbg_en[u] & cpu_debug_halt_i);
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st.cfg.route   <= {EXTS{`ROUTE_RESET}};
         st.cfg.enc_sel <= {UNITS{`ENC_SEL_RESET}};
         st.cfg.dbg_en  <= `DEBUG_ENABLE_RESET;
         st.rsp         <= '0;
         st.clk_n       <= 1'b1;
         st.dbg_n       <= '1;
      end else begin
         st <= next_st;
      end
   end

   // outputs
   assign wb_ack_o      = st.rsp.ack;
   assign wb_dat_o      = st.rsp.dat;
   assign trips_o.ext_n = ext_out_n;
   assign trips_o.enc_n = enc_trip_n;
   assign trips_o.clk_n = st.clk_n;
   assign trips_o.dbg_n = st.dbg_n;

endmodule : pwm_trip_input_routing

/* dv/trip_checker.sv */
module trip_checker #(
   parameter int FILTER_CYCLES = 6
) (
   input wire logic                  clk_i,
   input wire logic                  resetn_i,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_we_i,
   input wire logic [7:0]            wb_adr_i,
   input wire logic [3:0]            wb_sel_i,
   input wire logic [31:0]           wb_dat_i,
   input wire logic                  wb_ack_o,
   input wire logic [2:0]            ext_trip_n_i,
   input wire logic [1:0]            encoder_phase_error_i,
   input wire logic                  osc_fail_i,
   input wire logic                  pll_slip_i,
   input wire logic                  cpu_debug_halt_i,
   input wire trip_pkg::trip_bus_type trips_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import trip_pkg::*;
   // shadow of route a only: external trips b and c are judged by the bench
   logic [2:0]               route_a;
   logic [FILTER_CYCLES+3:0] hist;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         route_a <= 3'h1;
         hist    <= '1;
      end else begin
         hist <= {hist[FILTER_CYCLES+2:0], ext_trip_n_i[0]};
         if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i[7:2] == 6'h00 && wb_sel_i[2])
            route_a <= wb_dat_i[18:16];
      end
   end
   property p_route_direct;
      route_a == 3'h1 |-> trips_o.ext_n[0] == ext_trip_n_i[0];
   endproperty
   a_route_direct: assert property (p_route_direct) else $error("direct path differs from pin");
   property p_route_sync;
      route_a == 3'h2 && $past(route_a, 3) == 3'h2 |-> trips_o.ext_n[0] == $past(ext_trip_n_i[0], 2);
   endproperty
   a_route_sync: assert property (p_route_sync) else $error("synced path not two cycles late");
   // a loose middle window keeps this safe against a one-cycle offset of the filter
   property p_filter_hold;
      route_a == 3'h4 && $past(route_a, 9) == 3'h4 && $changed(trips_o.ext_n[0])
         |-> hist[FILTER_CYCLES:3] == {(FILTER_CYCLES-2){trips_o.ext_n[0]}};
   endproperty
   a_filter_hold: assert property (p_filter_hold) else $error("filter passed an unsettled level");
   property p_bad_code;
      !(route_a inside {3'h1, 3'h2, 3'h4}) && $past(route_a, 2) == route_a |-> trips_o.ext_n[0];
   endproperty
   a_bad_code: assert property (p_bad_code) else $error("bad route code let a trip through");
   property p_clk_fault;
      $past(resetn_i) |-> trips_o.clk_n == !($past(osc_fail_i) || $past(pll_slip_i));
   endproperty
   a_clk_fault: assert property (p_clk_fault) else $error("clock trip does not follow flags");
   property p_clk_sticky;
      (osc_fail_i || pll_slip_i) [*3] |-> !trips_o.clk_n;
   endproperty
   a_clk_sticky: assert property (p_clk_sticky) else $error("clock trip dropped while flag set");
   property p_enc_quiet;
      $past(resetn_i) && $past(encoder_phase_error_i) == 2'h0 |-> trips_o.enc_n == 7'h7F;
   endproperty
   a_enc_quiet: assert property (p_enc_quiet) else $error("encoder trip without error");
   property p_dbg_quiet;
      $past(resetn_i) && !$past(cpu_debug_halt_i) |-> trips_o.dbg_n == 7'h7F;
   endproperty
   a_dbg_quiet: assert property (p_dbg_quiet) else $error("debug trip without halt");
   property p_ack_once;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
endmodule : trip_checker

bind pwm_trip_input_routing trip_checker #(.FILTER_CYCLES(FILTER_CYCLES)) i_trip_checker (
   .clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .ext_trip_n_i(ext_trip_n_i), .encoder_phase_error_i(encoder_phase_error_i), .osc_fail_i(osc_fail_i),
   .pll_slip_i(pll_slip_i), .cpu_debug_halt_i(cpu_debug_halt_i), .trips_o(trips_o));

/* dv/trip_source.sv */
module trip_source #(
   parameter int PRESCALE_PRODUCT = 1
) (
   input  wire logic  clk_i,
   output logic [2:0] ext_trip_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial ext_trip_n_o = 3'h7;
   // shortest low time the fault circuit keeps for each path
   function automatic int min_width(input logic [2:0] route);
      case (route)
         3'h1: return 2 * PRESCALE_PRODUCT;
         3'h2: return 2;
         default: return 2 + 6;
      endcase
   endfunction : min_width
   // the line is driven high again after len clock cycles low
   task automatic pulse(input int idx, input int len);
      @(posedge clk_i);
      ext_trip_n_o[idx] <= 1'b0;
      repeat (len) @(posedge clk_i);
      ext_trip_n_o[idx] <= 1'b1;
   endtask : pulse
endmodule : trip_source

/* dv/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import trip_pkg::*;
   logic         clk = 1'b0;
   logic         resetn = 1'b0;
   logic         cyc = 1'b0;
   logic         stb = 1'b0;
   logic         we = 1'b0;
   logic [7:0]   adr = 8'h00;
   logic [3:0]   sel = 4'h0;
   logic [31:0]  wdat = 32'h0;
   logic [31:0]  rdat;
   logic         ack;
   logic [2:0]   pins_n;
   logic [1:0]   enc_err = 2'h0;
   logic         osc_fail = 1'b0;
   logic         pll_slip = 1'b0;
   logic         halt = 1'b0;
   trip_bus_type trips;
   int           n_mismatch = 0;
   int           samples_checked = 0;
   always #50 clk = ~clk;
   trip_source #(.PRESCALE_PRODUCT(1)) i_trip_source (.clk_i(clk), .ext_trip_n_o(pins_n));
   pwm_trip_input_routing #(.FILTER_CYCLES(6)) i_pwm_trip_input_routing (
      .clk_i(clk), .resetn_i(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_trip_n_i(pins_n),
      .encoder_phase_error_i(enc_err), .osc_fail_i(osc_fail), .pll_slip_i(pll_slip),
      .cpu_debug_halt_i(halt), .trips_o(trips));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
      do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
      if (ack !== 1'b1) n_mismatch++;
      r = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      wb(a, 1'b1, d, s, r);
   endtask : wr
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      wb(a, 1'b0, 32'h0, 4'hF, r);
      check(name, r, exp);
   endtask : rd_chk
   // counts low samples of one delivered trip while the source pulses its pin
   task automatic pulse_chk(input int idx, input logic [2:0] route, input int extra, input int exp);
      int len;
      int cnt;
      len = i_trip_source.min_width(route) + extra;
      cnt = 0;
      fork
         i_trip_source.pulse(idx, len);
         repeat (len + 16) begin
            @(posedge clk);
            if (trips.ext_n[idx] === 1'b0) cnt++;
         end
      join
      check("ext_n low cycles", cnt, exp);
   endtask : pulse_chk
   task automatic t_reset;
      rd_chk("route_lo", 8'h00, 32'h01010000);
      rd_chk("route_hi", 8'h04, 32'h00000001);
      rd_chk("enc_lo", 8'h08, 32'h01010101);
      rd_chk("enc_hi", 8'h0C, 32'h00010101);
      rd_chk("dbg_en", 8'h10, 32'h0);
      rd_chk("unmapped", 8'h40, 32'h0);
      rd_chk("status", 8'h14, 32'h077F17F7);
      for (int i = 0; i < 3; i++) pulse_chk(i, 3'h1, 0, 2);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_paths;
      wr(8'h00, 32'h04020000, 4'hF);
      wr(8'h04, 32'h00000004, 4'hF);
      pulse_chk(0, 3'h2, 0, 2);
      pulse_chk(1, 3'h4, 0, 8);
      pulse_chk(1, 3'h4, -3, 0);
      pulse_chk(2, 3'h4, 0, 8);
      wr(8'h00, 32'h03040000, 4'h4);
      rd_chk("route_lo", 8'h00, 32'h04040000);
      pulse_chk(0, 3'h4, 0, 8);
      wr(8'h00, 32'h00030000, 4'h4);
      pulse_chk(0, 3'h3, 0, 0);
      wr(8'h00, 32'h01010000, 4'hF);
      $display("t_paths done");
   endtask : t_paths
   task automatic t_encoder;
      logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
      logic       exp;
      foreach (codes[c]) begin
         wr(8'h08, {4{5'h0, codes[c]}}, 4'hF);
         wr(8'h0C, {8'h0, {3{5'h0, codes[c]}}}, 4'hF);
         rd_chk("enc_lo", 8'h08, {4{5'h0, codes[c]}});
         for (int e = 1; e < 4; e++) begin
            enc_err <= e[1:0];
            repeat (2) @(posedge clk);
            exp = codes[c] == 3'h1 ? 1'b0 : codes[c] == 3'h2 ? !e[0] : codes[c] == 3'h4 ? !e[1] : 1'b1;
            check("enc_n", trips.enc_n, {7{exp}});
         end
         enc_err <= 2'h0;
      end
      $display("t_encoder done");
   endtask : t_encoder
   task automatic t_clock;
      osc_fail <= 1'b1;
      repeat (2) @(posedge clk);
      check("clk_n osc", trips.clk_n, 1'b0);
      repeat (20) @(posedge clk);
      check("clk_n held", trips.clk_n, 1'b0);
      osc_fail <= 1'b0;
      pll_slip <= 1'b1;
      repeat (2) @(posedge clk);
      check("clk_n slip", trips.clk_n, 1'b0);
      pll_slip <= 1'b0;
      repeat (2) @(posedge clk);
      check("clk_n clear", trips.clk_n, 1'b1);
      $display("t_clock done");
   endtask : t_clock
   task automatic t_debug;
      halt <= 1'b1;
      repeat (2) @(posedge clk);
      check("dbg_n off", trips.dbg_n, 7'h7F);
      wr(8'h10, 32'h00000055, 4'h1);
      repeat (2) @(posedge clk);
      check("dbg_n on", trips.dbg_n, 7'h2A);
      halt <= 1'b0;
      repeat (2) @(posedge clk);
      check("dbg_n idle", trips.dbg_n, 7'h7F);
      $display("t_debug done");
   endtask : t_debug
   // a reset in mid-run must bring back the power-up routing and enables
   task automatic t_rereset;
      wr(8'h00, 32'h04040000, 4'hF);
      @(posedge clk);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      rd_chk("route_lo again", 8'h00, 32'h01010000);
      rd_chk("route_hi again", 8'h04, 32'h00000001);
      rd_chk("dbg_en again", 8'h10, 32'h0);
      $display("t_rereset done");
   endtask : t_rereset
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_paths();
      t_encoder();
      t_clock();
      t_debug();
      t_rereset();
      wrap_up();
   end
endmodule : tb_top
